// ===== rdpc_params.svh
/*
  Constants for the read data parity checker: widths, latencies, reset values.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef RDPC_PARAMS_SVH
`define RDPC_PARAMS_SVH

`define RDPC_DATA_BYTES 8
`define RDPC_ADDR_W 29
`define RDPC_CTRL_W 8
`define RDPC_PARITY_ERROR_OUT_N_LAT 2
`define RDPC_PARITY_ERROR_OUT_N_LAT_DP 3
`define RDPC_ADDR_RST 29'h0000_0000
`define RDPC_CTRL_RST 8'h00

`endif

// ===== rdpc_pkg.sv
/*
  Types shared by the read data parity checker files.
  Assumes rdpc_params.svh is on the include path.
*/
`default_nettype none
`include "rdpc_params.svh"

package rdpc_pkg;
  typedef enum logic [1:0] {
    RDPC_MC_IDLE = 2'b00,
    RDPC_MC_PEND = 2'b01,
    RDPC_MC_TAKEN = 2'b10
  } rdpc_mc_e;
  typedef logic [`RDPC_ADDR_W-1:0] rdpc_addr_t;
  typedef logic [`RDPC_CTRL_W-1:0] rdpc_ctrl_t;
endpackage
`default_nettype wire

// ===== rdpc_lane_check.sv
/*
  Per-lane even parity check over the byte lanes that carry valid read data.
  Assumes data, parity and lane enables are stable in the burst-ready clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "rdpc_params.svh"

module rdpc_lane_check #(
  parameter int NBYTES = `RDPC_DATA_BYTES
) (
  input wire logic [NBYTES*8-1:0] dataIn,
  input wire logic [NBYTES-1:0] parityIn,
  input wire logic [NBYTES-1:0] laneValid,
  output logic errAny
);
  function automatic logic lane_bad(input logic [7:0] b, input logic p);
    lane_bad = ^{b, p};
  endfunction

  logic [NBYTES-1:0] laneErr;

  for (genvar i = 0; i < NBYTES; i++) begin : g_lane
    assign laneErr[i] = laneValid[i] & lane_bad(dataIn[i*8 +: 8], parityIn[i]);
  end

  assign errAny = |laneErr;
endmodule
`default_nettype wire

// ===== rdpc_read_data_parity_checker.sv
/*
  Read-data parity checker: parity status output, machine check capture, exception.
  Assumes a single bus clock, synchronous inputs, and that the external party
  drives the parity enable input in the clock that the error is detected.
*/
// Functional notes
// - Parity error output driven two clocks after burst-ready for read data.
// - Output low one clock per erroring clock, high otherwise.
// - Only byte lanes carrying valid read data are parity checked.
// - In dual processing mode the output comes three clocks after burst-ready, one clock late.
// - Parity enable active at detection captures address and control.
// - Captured error with check enable set raises exception before next instruction.
`timescale 1ns/100ps
`default_nettype none
`include "rdpc_params.svh"

module rdpc_read_data_parity_checker #(
  parameter int NBYTES = `RDPC_DATA_BYTES,
  parameter int LAT = `RDPC_PARITY_ERROR_OUT_N_LAT
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic burst_ready_n,
  input wire logic readCycle,
  input wire logic [NBYTES*8-1:0] readData,
  input wire logic [NBYTES-1:0] readParity,
  input wire logic [NBYTES-1:0] byteEnable_n,
  input wire logic [`RDPC_ADDR_W-1:0] cycleAddr,
  input wire logic [`RDPC_CTRL_W-1:0] cycleCtrl,
  input wire logic parity_exception_enable_n,
  input wire logic machine_check_enable_bit,
  input wire logic dualProcMode,
  input wire logic instrBoundary,
  input wire logic mcAck,
  output logic parity_error_out_n,
  output logic [`RDPC_ADDR_W-1:0] mcAddr,
  output logic [`RDPC_CTRL_W-1:0] mcCtrl,
  output logic mcValid,
  output logic mcException
);
  // Pipe needs two taps at least
  if (LAT < 2 || NBYTES < 1) begin : g_bad_param
    $error("rdpc: bad parameters");
  end

  logic laneErr;
  rdpc_lane_check #(.NBYTES(NBYTES)) u_lane (
    .dataIn(readData),
    .parityIn(readParity),
    .laneValid(~byteEnable_n),
    .errAny(laneErr)
  );

  // Error detected in the burst-ready clock of a read
  wire detect = readCycle & ~burst_ready_n & laneErr;
  wire capture = detect & ~parity_exception_enable_n;

  logic [LAT-1:0] errPipe_ff;
  wire [LAT-1:0] nxt_errPipe = {errPipe_ff[LAT-2:0], detect};
  // dual mode taps one stage later
  wire pipeTap = dualProcMode ? errPipe_ff[LAT-1] : errPipe_ff[LAT-2];
  logic pchkN_ff;
  wire nxt_pchkN = ~pipeTap;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      errPipe_ff <= '0;
      pchkN_ff <= 1'b1;
    end else begin
      errPipe_ff <= nxt_errPipe;
      pchkN_ff <= nxt_pchkN;
    end
  end

  assign parity_error_out_n = pchkN_ff;

  logic [`RDPC_ADDR_W-1:0] mcAddr_ff;
  logic [`RDPC_CTRL_W-1:0] mcCtrl_ff;
  rdpc_pkg::rdpc_mc_e mcState_ff;
  rdpc_pkg::rdpc_mc_e nxt_mcState;

  always_comb begin
    nxt_mcState = mcState_ff;
    unique case (mcState_ff)
      rdpc_pkg::RDPC_MC_IDLE: begin
        if (capture && machine_check_enable_bit) begin
          nxt_mcState = rdpc_pkg::RDPC_MC_PEND;
        end
      end
      rdpc_pkg::RDPC_MC_PEND: begin
        if (instrBoundary) begin
          nxt_mcState = rdpc_pkg::RDPC_MC_TAKEN;
        end
      end
      rdpc_pkg::RDPC_MC_TAKEN: begin
        if (mcAck && capture && machine_check_enable_bit) begin
          nxt_mcState = rdpc_pkg::RDPC_MC_PEND;
        end else if (mcAck) begin
          nxt_mcState = rdpc_pkg::RDPC_MC_IDLE;
        end
      end
      default: nxt_mcState = rdpc_pkg::RDPC_MC_IDLE;
    endcase
  end

  logic mcValid_ff;
  logic mcExc_ff;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mcAddr_ff <= `RDPC_ADDR_RST;
      mcCtrl_ff <= `RDPC_CTRL_RST;
      mcValid_ff <= 1'b0;
      mcState_ff <= rdpc_pkg::RDPC_MC_IDLE;
      mcExc_ff <= 1'b0;
    end else begin
      if (capture) begin
        mcAddr_ff <= cycleAddr;
        mcCtrl_ff <= cycleCtrl;
      end
      mcValid_ff <= capture | (mcValid_ff & ~mcAck);
      mcState_ff <= nxt_mcState;
      mcExc_ff <= (nxt_mcState == rdpc_pkg::RDPC_MC_TAKEN);
    end
  end

  assign mcAddr = mcAddr_ff;
  assign mcCtrl = mcCtrl_ff;
  assign mcValid = mcValid_ff;
  assign mcException = mcExc_ff;

  // Assertions
  // exact two clock status
  parity_error_out_n_latency_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!$past(dualProcMode) && !$past(rst) && !$past(rst, 2))
    |-> (parity_error_out_n == !$past(detect, 2)))
    else $error("parity status latency wrong");

  parity_error_out_n_two_a: assert property (@(posedge ref_clk) disable iff (rst)
    (detect && !dualProcMode ##1 !dualProcMode ##1 !dualProcMode) |-> !parity_error_out_n)
    else $error("parity error not shown two clocks later");

  parity_error_out_n_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    (!dualProcMode && !$past(detect, 2) && $past(!dualProcMode)) |-> parity_error_out_n)
    else $error("parity error output low without cause");

  parity_error_out_n_dp_a: assert property (@(posedge ref_clk) disable iff (rst)
    (detect && dualProcMode ##1 dualProcMode [*3]) |-> !parity_error_out_n)
    else $error("dual mode latency wrong");

  parity_error_out_n_dp_exact_a: assert property (@(posedge ref_clk) disable iff (rst)
    ($past(dualProcMode) && !$past(rst) && !$past(rst, 2) && !$past(rst, 3))
    |-> (parity_error_out_n == !$past(detect, 3)))
    else $error("dual mode status wrong");

  lane_mask_a: assert property (@(posedge ref_clk) disable iff (rst)
    (&byteEnable_n) |-> !detect)
    else $error("parity checked on invalid lanes");

  mc_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    capture |=> (mcAddr == $past(cycleAddr)) && (mcCtrl == $past(cycleCtrl)) && mcValid)
    else $error("machine check capture missed");

  mc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !capture |=> $stable(mcAddr) && $stable(mcCtrl))
    else $error("machine check registers changed without capture");

  mc_clear_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mcAck && !capture) |=> !mcValid)
    else $error("machine check record not cleared");

  mc_exc_a: assert property (@(posedge ref_clk) disable iff (rst)
    (capture && machine_check_enable_bit && mcState_ff == rdpc_pkg::RDPC_MC_IDLE
     ##1 instrBoundary) |=> mcException)
    else $error("machine check exception not raised");

  exc_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mcException && !mcAck) |=> mcException)
    else $error("machine check exception dropped early");

  exc_rearm_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mcException && mcAck && capture && machine_check_enable_bit)
    |=> (mcState_ff == rdpc_pkg::RDPC_MC_PEND))
    else $error("machine check error lost at acknowledge");

  no_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
    (detect && parity_exception_enable_n && !mcValid) |=> !mcValid && $stable(mcAddr))
    else $error("capture without parity enable");

  exc_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    (mcState_ff == rdpc_pkg::RDPC_MC_IDLE && !(capture && machine_check_enable_bit))
    |=> !mcException)
    else $error("machine check exception without armed error");

  // Main scenarios
  cov_err: cover property (@(posedge ref_clk) disable iff (rst) detect ##2 !parity_error_out_n);
  cov_dual: cover property (@(posedge ref_clk) disable iff (rst)
    (detect && dualProcMode) ##3 !parity_error_out_n);
  cov_cap: cover property (@(posedge ref_clk) disable iff (rst) capture);
  cov_drop: cover property (@(posedge ref_clk) disable iff (rst)
    detect && parity_exception_enable_n);
  cov_exc: cover property (@(posedge ref_clk) disable iff (rst) $rose(mcException));
endmodule
`default_nettype wire

// ===== rdpc_mem_model.sv
/*
  Far-side memory model: returns read beats with even parity per lane, odd parity on lanes set in badLanes.
  Assumes the bench sets beat and badLanes at the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none
module rdpc_mem_model (
  input wire logic ref_clk,
  input wire logic beat,
  input wire logic [7:0] badLanes,
  output logic burst_ready_n,
  output logic [63:0] readData,
  output logic [7:0] readParity
);
  logic [63:0] d;
  initial begin
    burst_ready_n = 1'b1;
    readData = 64'h0000_0000_0000_0000;
    readParity = 8'h00;
  end
  always @(negedge ref_clk) begin
    #1;
    d = {$urandom, $urandom};
    burst_ready_n = !beat;
    readData = beat ? d : ~readData;
    for (int i = 0; i < 8; i++) begin
      readParity[i] = beat ? (^d[8*i+:8]) ^ badLanes[i] : ~readParity[i];
    end
  end
endmodule
`default_nettype wire

// ===== rdpc_read_data_parity_checker_bench.sv
/*
  Random bench with a cycle model of parity report, capture and exception.
  Assumes the memory model and the parity checker design files.
*/
`timescale 1ns/100ps
`default_nettype none
module rdpc_read_data_parity_checker_bench;
  logic ref_clk, rst, readCycle, beat, penN, mce, dual, bound, ack, brdyN;
  logic pchkN, mcValid, mcExc, pErr, pPen, pAck, pBound, expV, expE;
  logic [7:0] bad, beN, ctrl, pCtrl, expC, rpar, mcCtrl;
  logic [28:0] addr, pAddr, expA, mcAddr;
  logic [63:0] rdata;
  int hist[$];
  int failures, testsRun, lat, mcSt;
  rdpc_mem_model model (.ref_clk(ref_clk), .beat(beat), .badLanes(bad),
    .burst_ready_n(brdyN), .readData(rdata), .readParity(rpar));
  rdpc_read_data_parity_checker DUT (.ref_clk(ref_clk), .rst(rst), .burst_ready_n(brdyN),
    .readCycle(readCycle), .readData(rdata), .readParity(rpar), .byteEnable_n(beN),
    .cycleAddr(addr), .cycleCtrl(ctrl), .parity_exception_enable_n(penN),
    .machine_check_enable_bit(mce), .dualProcMode(dual), .instrBoundary(bound),
    .mcAck(ack), .parity_error_out_n(pchkN), .mcAddr(mcAddr), .mcCtrl(mcCtrl),
    .mcValid(mcValid), .mcException(mcExc));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && testsRun > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic step();
    if (mcSt == 2 && pAck) mcSt = 0;
    else if (mcSt == 1 && pBound) mcSt = 2;
    if (mcSt == 0 && pErr && !pPen && mce) mcSt = 1;
    expE = (mcSt == 2);
    if (pAck) expV = 1'b0;
    if (pErr && !pPen) begin
      expV = 1'b1;
      expA = pAddr;
      expC = pCtrl;
    end
    hist.push_back(int'(pErr));
    check("parity_error_out_n", pchkN, !(hist.size() >= lat && hist[hist.size()-lat] != 0));
    check("mcValid", mcValid, expV);
    if (expV) check("mcAddr", mcAddr, expA);
    if (expV) check("mcCtrl", mcCtrl, expC);
    check("mcException", mcExc, expE);
    beat = ($urandom % 3) != 0;
    readCycle = ($urandom % 8) != 0;
    bad = ($urandom % 3 == 0) ? 8'($urandom) : 8'h00;
    beN = 8'($urandom);
    addr = 29'($urandom);
    ctrl = 8'($urandom);
    penN = 1'($urandom);
    bound = !beat && ($urandom % 4 == 0);
    ack = !bound && ($urandom % 6 == 0);
    pErr = beat && readCycle && |(bad & ~beN);
    pPen = penN;
    pAck = ack;
    pBound = bound;
    pAddr = addr;
    pCtrl = ctrl;
  endtask
  initial begin
    void'($urandom(83));
    for (int cfg = 0; cfg < 4; cfg++) begin
      {readCycle, beat, bad, beN, addr, ctrl, penN, bound, ack} = '0;
      rst = 1'b1;
      mce = cfg[0];
      dual = cfg[1];
      lat = cfg[1] ? 3 : 2;
      hist.delete();
      {pErr, pPen, pAck, pBound, expV, expE} = '0;
      mcSt = 0;
      repeat (12) @(negedge ref_clk);
      rst = 1'b0;
      repeat (500) begin
        @(negedge ref_clk);
        step();
      end
      @(negedge ref_clk);
    end
    summarize();
  end
endmodule
`default_nettype wire
